// ---- hdl/multiply_alu_transfer_datapath.sv ----
`timescale 1ns/1ps
module multiply_alu_transfer_datapath (
	// Clock, reset, enable
	input  wire logic        sys_clk,
	input  wire logic        rst,
	input  wire logic        ce,
	// AXI4-Lite write
	input  wire logic        awvalid,
	input  wire logic [7:0]  awaddr,
	output logic             awready,
	input  wire logic        wvalid,
	input  wire logic [31:0] wdata,
	input  wire logic [3:0]  wstrb,
	output logic             wready,
	output logic             bvalid,
	output logic [1:0]       bresp,
	input  wire logic        bready,
	// AXI4-Lite read
	input  wire logic        arvalid,
	input  wire logic [7:0]  araddr,
	output logic             arready,
	output logic             rvalid,
	output logic [31:0]      rdata,
	output logic [1:0]       rresp,
	input  wire logic        rready
);
	logic                        aw_hold_r, w_hold_r;
	logic [7:0]                  aw_addr_r;
	logic [31:0]                 w_data_r;
	logic [3:0]                  w_strb_r;
	logic                        do_wr, wr_ok, busy, exec;
	logic [31:0]                 rd_val;
	logic                        rd_ok;
	mac_alu_pkg::ctrl_t          ctrl_r;
	mac_alu_pkg::instr_t         ir_r;
	mac_alu_pkg::exec_state_t    st_r;
	logic [3:0]                  cnt_r;
	logic [15:0]                 cyc_r;
	logic [15:0]                 x_r;
	logic [31:0]                 y_r, p_r;
	logic [35:0]                 acc_r [2];
	logic [3:0]                  dptr_r, cptr_r;
	logic                        neg_r, zero_r;
	logic [15:0]                 dmem [16];
	logic [15:0]                 cmem [16];
	logic [35:0]                 a_s, a_t, p_ext, p_al, y_ext, alu_res;
	logic [31:0]                 prod;
	logic [15:0]                 dm_rd, cm_rd, st_val, lim_hi, lim_lo;
	logic                        fn_wr, fn_flag, is_mul, mem_st, use_x, use_y, is_nop;
	logic                        y_zero, a_zero;
	logic [31:0]                 ctrl_m, x_m, dm_m, cm_m;

	function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] n,
			input logic [3:0] s);
		logic [31:0] r;
		r = o;
		for (int b = 0; b < 4; b++) begin
			if (s[b]) begin
				r[8*b +: 8] = n[8*b +: 8];
			end
		end
		return r;
	endfunction

	assign busy = (st_r != mac_alu_pkg::ST_IDLE);
	assign exec = ce && (st_r == mac_alu_pkg::ST_RUN);
	assign do_wr = aw_hold_r && w_hold_r && !bvalid;
	assign wr_ok = !busy && ((aw_addr_r[7:6] == mac_alu_pkg::WIN_DMEM) ||
		(aw_addr_r[7:6] == mac_alu_pkg::WIN_CMEM) || (aw_addr_r == mac_alu_pkg::OFS_CTRL) ||
		(aw_addr_r == mac_alu_pkg::OFS_INSTR) || (aw_addr_r == mac_alu_pkg::OFS_X) ||
		(aw_addr_r == mac_alu_pkg::OFS_Y) || (aw_addr_r == mac_alu_pkg::OFS_P) ||
		(aw_addr_r == mac_alu_pkg::OFS_PTR));

	// Byte-lane merges for bus writes
	assign ctrl_m = merge({27'h0, ctrl_r}, w_data_r, w_strb_r);
	assign x_m    = merge({16'h0000, x_r}, w_data_r, w_strb_r);
	assign dm_m   = merge({16'h0000, dmem[aw_addr_r[5:2]]}, w_data_r, w_strb_r);
	assign cm_m   = merge({16'h0000, cmem[aw_addr_r[5:2]]}, w_data_r, w_strb_r);

	// Write channel capture, either order
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			aw_hold_r <= 1'b0;
			w_hold_r  <= 1'b0;
			awready   <= 1'b0;
			wready    <= 1'b0;
			aw_addr_r <= 8'h00;
			w_data_r  <= 32'h0000_0000;
			w_strb_r  <= 4'h0;
			bvalid    <= 1'b0;
			bresp     <= mac_alu_pkg::RESP_OKAY;
		end else if (ce) begin
			if (awvalid && awready) begin
				aw_hold_r <= 1'b1;
				aw_addr_r <= {awaddr[7:2], 2'b00};
				awready   <= 1'b0;
			end else if (!aw_hold_r) begin
				awready <= 1'b1;
			end
			if (wvalid && wready) begin
				w_hold_r <= 1'b1;
				w_data_r <= wdata;
				w_strb_r <= wstrb;
				wready   <= 1'b0;
			end else if (!w_hold_r) begin
				wready <= 1'b1;
			end
			if (do_wr) begin
				aw_hold_r <= 1'b0;
				w_hold_r  <= 1'b0;
				bvalid    <= 1'b1;
				bresp     <= wr_ok ? mac_alu_pkg::RESP_OKAY : mac_alu_pkg::RESP_SLVERR;
			end else if (bready) begin
				bvalid <= 1'b0;
			end
		end
	end

	// Read decode
	always_comb begin
		rd_ok = 1'b1;
		rd_val = 32'h0000_0000;
		if (araddr[7:6] == mac_alu_pkg::WIN_DMEM) begin
			rd_val = {16'h0000, dmem[araddr[5:2]]};
		end else if (araddr[7:6] == mac_alu_pkg::WIN_CMEM) begin
			rd_val = {16'h0000, cmem[araddr[5:2]]};
		end else begin
			unique case ({araddr[7:2], 2'b00})
				mac_alu_pkg::OFS_CTRL:   rd_val = {27'h0, ctrl_r};
				mac_alu_pkg::OFS_INSTR:  rd_val = ir_r;
				mac_alu_pkg::OFS_STATUS: rd_val = {cyc_r, 13'h0, zero_r, neg_r, busy};
				mac_alu_pkg::OFS_X:      rd_val = {16'h0000, x_r};
				mac_alu_pkg::OFS_Y:      rd_val = y_r;
				mac_alu_pkg::OFS_P:      rd_val = p_r;
				mac_alu_pkg::OFS_A0_LO:  rd_val = acc_r[0][31:0];
				mac_alu_pkg::OFS_A0_HI:  rd_val = {28'h0, acc_r[0][35:32]};
				mac_alu_pkg::OFS_A1_LO:  rd_val = acc_r[1][31:0];
				mac_alu_pkg::OFS_A1_HI:  rd_val = {28'h0, acc_r[1][35:32]};
				mac_alu_pkg::OFS_PTR:    rd_val = {20'h0, cptr_r, 4'h0, dptr_r};
				default:                 rd_ok = 1'b0;
			endcase
		end
	end

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			arready <= 1'b0;
			rvalid  <= 1'b0;
			rdata   <= 32'h0000_0000;
			rresp   <= mac_alu_pkg::RESP_OKAY;
		end else if (ce) begin
			if (arvalid && arready) begin
				arready <= 1'b0;
				rvalid  <= 1'b1;
				rdata   <= rd_val;
				rresp   <= rd_ok ? mac_alu_pkg::RESP_OKAY : mac_alu_pkg::RESP_SLVERR;
			end else if (rvalid && rready) begin
				rvalid  <= 1'b0;
				arready <= 1'b1;
			end else if (!rvalid) begin
				arready <= 1'b1;
			end
		end
	end

	// Control register and instruction issue
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			ctrl_r <= mac_alu_pkg::CTRL_RST;
			ir_r   <= '0;
		end else if (ce && do_wr && wr_ok) begin
			if (aw_addr_r == mac_alu_pkg::OFS_CTRL) begin
				ctrl_r <= ctrl_m[4:0];
			end
			if (aw_addr_r == mac_alu_pkg::OFS_INSTR) begin
				ir_r <= merge(ir_r, w_data_r, w_strb_r);
			end
		end
	end

	// Transfer classes
	assign is_nop = (ir_r.func == mac_alu_pkg::F_NONE) && (ir_r.xfer == mac_alu_pkg::T_NONE);
	assign mem_st = (ir_r.xfer >= mac_alu_pkg::T_ST_Y);
	assign use_x  = (ir_r.xfer == mac_alu_pkg::T_LD_YX) || (ir_r.xfer == mac_alu_pkg::T_LD_YAT_X) ||
		(ir_r.xfer == mac_alu_pkg::T_XC_YX);
	assign use_y  = (ir_r.xfer != mac_alu_pkg::T_NONE) && (ir_r.xfer != mac_alu_pkg::T_LD_YAT_X);
	assign y_zero = !ctrl_r.low_half_zero_select[0];
	assign a_zero = !ctrl_r.low_half_zero_select[1];

	// Sequencer
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			st_r  <= mac_alu_pkg::ST_IDLE;
			cnt_r <= 4'h0;
			cyc_r <= 16'h0000;
		end else if (ce) begin
			unique case (st_r)
				mac_alu_pkg::ST_IDLE: begin
					if (do_wr && wr_ok && aw_addr_r == mac_alu_pkg::OFS_INSTR) begin
						st_r  <= mac_alu_pkg::ST_RUN;
						cyc_r <= 16'h0000;
					end
				end
				mac_alu_pkg::ST_RUN: begin
					cyc_r <= cyc_r + 16'h0001;
					if (mem_st) begin
						st_r  <= mac_alu_pkg::ST_HOLD;
						cnt_r <= mac_alu_pkg::MEM_WR_EXTRA;
					end else if (is_nop && ir_r.rep > 4'h1) begin
						st_r  <= mac_alu_pkg::ST_HOLD;
						cnt_r <= ir_r.rep - 4'h1;
					end else begin
						st_r <= mac_alu_pkg::ST_IDLE;
					end
				end
				mac_alu_pkg::ST_HOLD: begin
					cyc_r <= cyc_r + 16'h0001;
					cnt_r <= cnt_r - 4'h1;
					if (cnt_r == 4'h1) begin
						st_r <= mac_alu_pkg::ST_IDLE;
					end
				end
				default: st_r <= mac_alu_pkg::ST_IDLE;
			endcase
		end
	end

	// Datapath operands, all taken from pre-instruction state
	assign a_s   = ir_r.source_accumulator ? acc_r[1] : acc_r[0];
	assign a_t   = ir_r.moved_acc_select ? acc_r[1] : acc_r[0];
	assign dm_rd = dmem[dptr_r];
	assign cm_rd = cmem[cptr_r];
	assign prod  = $signed(x_r) * $signed(y_r[31:16]);
	// sign extension of p and y
	assign p_ext = {{4{p_r[31]}}, p_r};
	assign y_ext = {{4{y_r[31]}}, y_r};
	always_comb begin
		unique case (ctrl_r.align)
			2'h1:    p_al = {{2{p_ext[35]}}, p_ext[35:2]};
			2'h2:    p_al = {p_ext[33:0], 2'b00};
			default: p_al = p_ext;
		endcase
	end

	assign is_mul  = (ir_r.func >= mac_alu_pkg::F_MUL) && (ir_r.func <= mac_alu_pkg::F_SUBP_MUL);
	assign fn_flag = (ir_r.func >= mac_alu_pkg::F_P_MUL);
	assign fn_wr   = fn_flag && (ir_r.func < mac_alu_pkg::F_CMPSUB);

	always_comb begin
		unique case (ir_r.func)
			mac_alu_pkg::F_P_MUL, mac_alu_pkg::F_P:       alu_res = p_al;
			mac_alu_pkg::F_ADDP_MUL, mac_alu_pkg::F_ADDP: alu_res = a_s + p_al;
			mac_alu_pkg::F_SUBP_MUL, mac_alu_pkg::F_SUBP: alu_res = a_s - p_al;
			mac_alu_pkg::F_Y:                             alu_res = y_ext;
			mac_alu_pkg::F_ADDY:                          alu_res = a_s + y_ext;
			mac_alu_pkg::F_SUBY, mac_alu_pkg::F_CMPSUB:   alu_res = a_s - y_ext;
			mac_alu_pkg::F_AND, mac_alu_pkg::F_CMPAND:    alu_res = a_s & y_ext;
			mac_alu_pkg::F_OR:                            alu_res = a_s | y_ext;
			mac_alu_pkg::F_XOR:                           alu_res = a_s ^ y_ext;
			default:                                      alu_res = 36'h0_0000_0000;
		endcase
	end

	always_comb begin
		lim_hi = a_t[31:16];
		lim_lo = a_t[15:0];
		if (ctrl_r.overflow_limit_select && (a_t[35:31] != {5{a_t[35]}})) begin
			lim_hi = a_t[35] ? 16'h8000 : 16'h7fff;
			lim_lo = a_t[35] ? 16'h0000 : 16'hffff;
		end
	end

	always_comb begin
		unique case (ir_r.xfer)
			mac_alu_pkg::T_ST_Y, mac_alu_pkg::T_XC_YX, mac_alu_pkg::T_XC_Y: st_val = y_r[31:16];
			mac_alu_pkg::T_ST_YLO, mac_alu_pkg::T_XC_YLO:                   st_val = y_r[15:0];
			mac_alu_pkg::T_ST_ACCLO:                                        st_val = lim_lo;
			default:                                                        st_val = lim_hi;
		endcase
	end

	// Flags from function result
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			neg_r  <= 1'b0;
			zero_r <= 1'b0;
		end else if (exec && fn_flag) begin
			neg_r  <= alu_res[35];
			zero_r <= (alu_res == 36'h0_0000_0000);
		end
	end

	// Product register
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			p_r <= 32'h0000_0000;
		end else if (ce) begin
			if (do_wr && wr_ok && aw_addr_r == mac_alu_pkg::OFS_P) begin
				p_r <= merge(p_r, w_data_r, w_strb_r);
			end
			if (exec && is_mul) begin
				p_r <= prod;
			end
		end
	end

	// First operand register
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			x_r <= 16'h0000;
		end else if (ce) begin
			if (do_wr && wr_ok && aw_addr_r == mac_alu_pkg::OFS_X) begin
				x_r <= x_m[15:0];
			end
			// x from coefficient or data memory
			if (exec && use_x) begin
				x_r <= cm_rd;
			end else if (exec && ir_r.xfer == mac_alu_pkg::T_LD_XY) begin
				x_r <= dm_rd;
			end
		end
	end

	// Second operand register
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			y_r <= 32'h0000_0000;
		end else if (ce) begin
			if (do_wr && wr_ok && aw_addr_r == mac_alu_pkg::OFS_Y) begin
				y_r <= merge(y_r, w_data_r, w_strb_r);
			end
			if (exec) begin
				unique case (ir_r.xfer)
					mac_alu_pkg::T_LD_YX, mac_alu_pkg::T_LD_Y, mac_alu_pkg::T_XC_YX,
					mac_alu_pkg::T_XC_Y: begin
						y_r[31:16] <= dm_rd;
						if (y_zero) begin
							y_r[15:0] <= 16'h0000;
						end
					end
					mac_alu_pkg::T_LD_YAT_X: begin
						y_r[31:16] <= a_t[31:16];
						if (y_zero) begin
							y_r[15:0] <= 16'h0000;
						end
					end
					mac_alu_pkg::T_LD_YLO, mac_alu_pkg::T_XC_YLO: y_r[15:0] <= dm_rd;
					default: ;
				endcase
			end
		end
	end

	// Accumulators
	for (genvar i = 0; i < 2; i++) begin : g_acc
		always_ff @(posedge sys_clk) begin
			if (rst) begin
				acc_r[i] <= 36'h0_0000_0000;
			end else if (exec) begin
				if (fn_wr && ir_r.dest_acc == 1'(i)) begin
					acc_r[i] <= alu_res;
				end
				if (ir_r.moved_acc_select == 1'(i)) begin
					unique case (ir_r.xfer)
						// upper load, guard from bit 31
						mac_alu_pkg::T_LD_ACC, mac_alu_pkg::T_XC_ACC:
							acc_r[i] <= {{4{dm_rd[15]}}, dm_rd,
								a_zero ? 16'h0000 : acc_r[i][15:0]};
						mac_alu_pkg::T_LD_ACCLO, mac_alu_pkg::T_XC_ACCLO:
							acc_r[i][15:0] <= dm_rd;
						default: ;
					endcase
				end
			end
		end
	end

	// Pointers and memories
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			dptr_r <= 4'h0;
			cptr_r <= 4'h0;
		end else if (ce) begin
			if (do_wr && wr_ok && aw_addr_r == mac_alu_pkg::OFS_PTR) begin
				dptr_r <= w_data_r[3:0];
				cptr_r <= w_data_r[mac_alu_pkg::PTR_C_POS +: 4];
			end
			if (exec && use_y) begin
				unique case (ir_r.pmod)
					mac_alu_pkg::PM_INC:  dptr_r <= dptr_r + 4'h1;
					mac_alu_pkg::PM_DEC:  dptr_r <= dptr_r - 4'h1;
					mac_alu_pkg::PM_INC2: dptr_r <= dptr_r + 4'h2;
					default:              dptr_r <= dptr_r;
				endcase
			end
			if (exec && use_x) begin
				cptr_r <= cptr_r + 4'h1;
			end
		end
	end

	always_ff @(posedge sys_clk) begin
		if (ce) begin
			if (do_wr && wr_ok && aw_addr_r[7:6] == mac_alu_pkg::WIN_DMEM) begin
				dmem[aw_addr_r[5:2]] <= dm_m[15:0];
			end
			if (do_wr && wr_ok && aw_addr_r[7:6] == mac_alu_pkg::WIN_CMEM) begin
				cmem[aw_addr_r[5:2]] <= cm_m[15:0];
			end
			if (exec && mem_st) begin
				dmem[dptr_r] <= st_val;
			end
		end
	end

	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (rst);

	sequence s_run(logic [3:0] f);
		exec && ir_r.func == f;
	endsequence
	sequence s_nop4;
		exec && is_nop && ir_r.rep == 4'h4 ##1 ce [*3];
	endsequence
	sequence s_wr_tail;
		st_r == mac_alu_pkg::ST_HOLD && cnt_r == mac_alu_pkg::MEM_WR_EXTRA
		##1 st_r == mac_alu_pkg::ST_IDLE;
	endsequence

	a_p_product: assert property (s_run(mac_alu_pkg::F_MUL) |=> p_r == $past(prod))
		else $error("product register wrong");
	a_copy_mul: assert property (s_run(mac_alu_pkg::F_P_MUL) && ir_r.dest_acc &&
		ir_r.xfer == mac_alu_pkg::T_NONE && ctrl_r.align == 2'h1 |=>
		acc_r[1] == {{6{$past(p_r[31])}}, $past(p_r[31:2])} && p_r == $past(prod))
		else $error("copy and multiply wrong");
	a_acc_add: assert property (s_run(mac_alu_pkg::F_ADDY) && ir_r.dest_acc &&
		ir_r.xfer == mac_alu_pkg::T_NONE |=> acc_r[1] == $past(a_s) + $past(y_ext))
		else $error("accumulate of y wrong");
	a_cmp_keep: assert property (exec && ir_r.func >= mac_alu_pkg::F_CMPSUB &&
		ir_r.xfer == mac_alu_pkg::T_NONE |=> $stable(acc_r[0]) && $stable(acc_r[1]))
		else $error("compare changed an accumulator");
	a_ylow_keep: assert property (exec && ir_r.xfer == mac_alu_pkg::T_LD_YLO |=>
		y_r == {$past(y_r[31:16]), $past(dm_rd)})
		else $error("low load disturbed upper half");
	a_yclr_load: assert property (exec && ir_r.xfer == mac_alu_pkg::T_LD_Y && y_zero |=>
		y_r == {$past(dm_rd), 16'h0000})
		else $error("upper load zeroing wrong");
	a_guard_fill: assert property (exec && ir_r.xfer == mac_alu_pkg::T_LD_ACC &&
		!ir_r.moved_acc_select |=> acc_r[0][35:16] == {{4{$past(dm_rd[15])}}, $past(dm_rd)})
		else $error("guard bits not filled");
	a_wr_two: assert property (exec && mem_st ##1 ce |-> s_wr_tail)
		else $error("memory write not two cycles");
	a_hold_end: assert property (st_r == mac_alu_pkg::ST_HOLD && ce && cnt_r == 4'h1 |=>
		st_r == mac_alu_pkg::ST_IDLE)
		else $error("hold did not end");
	a_nop_four: assert property (s_nop4 |=> st_r == mac_alu_pkg::ST_IDLE && cyc_r == 16'h0004)
		else $error("repeated idle length wrong");
	a_addr_only: assert property (exec && ir_r.xfer == mac_alu_pkg::T_ADDR &&
		ir_r.pmod == mac_alu_pkg::PM_INC && ir_r.func == mac_alu_pkg::F_NONE |=>
		dptr_r == $past(dptr_r) + 4'h1 && $stable(y_r) && $stable(x_r))
		else $error("address-only transfer moved data");
endmodule

// ---- hdl/mac_alu_pkg.sv ----
package mac_alu_pkg;
	// Register byte offsets
	localparam logic [7:0] OFS_CTRL   = 8'h00;
	localparam logic [7:0] OFS_INSTR  = 8'h04;
	localparam logic [7:0] OFS_STATUS = 8'h08;
	localparam logic [7:0] OFS_X      = 8'h0c;
	localparam logic [7:0] OFS_Y      = 8'h10;
	localparam logic [7:0] OFS_P      = 8'h14;
	localparam logic [7:0] OFS_A0_LO  = 8'h18;
	localparam logic [7:0] OFS_A0_HI  = 8'h1c;
	localparam logic [7:0] OFS_A1_LO  = 8'h20;
	localparam logic [7:0] OFS_A1_HI  = 8'h24;
	localparam logic [7:0] OFS_PTR    = 8'h28;
	localparam logic [1:0] WIN_DMEM   = 2'h1;
	localparam logic [1:0] WIN_CMEM   = 2'h2;
	localparam int PTR_C_POS = 8;
	localparam logic [4:0] CTRL_RST = 5'h00;
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	// Extra cycles of an instruction that writes data memory
	localparam logic [3:0] MEM_WR_EXTRA = 4'h1;

	typedef struct packed {
		logic       overflow_limit_select;
		logic [1:0] low_half_zero_select;
		logic [1:0] align;
	} ctrl_t;

	typedef enum logic [3:0] {
		F_NONE = 4'h0, F_MUL = 4'h1, F_P_MUL = 4'h2, F_ADDP_MUL = 4'h3,
		F_SUBP_MUL = 4'h4, F_P = 4'h5, F_ADDP = 4'h6, F_SUBP = 4'h7,
		F_Y = 4'h8, F_ADDY = 4'h9, F_SUBY = 4'ha, F_AND = 4'hb,
		F_OR = 4'hc, F_XOR = 4'hd, F_CMPSUB = 4'he, F_CMPAND = 4'hf
	} func_t;

	typedef enum logic [4:0] {
		T_NONE = 5'h00, T_LD_YX = 5'h01, T_LD_YAT_X = 5'h02, T_LD_Y = 5'h03,
		T_LD_YLO = 5'h04, T_LD_ACC = 5'h05, T_LD_ACCLO = 5'h06, T_LD_XY = 5'h07,
		T_ADDR = 5'h08, T_ST_Y = 5'h09, T_ST_YLO = 5'h0a, T_ST_ACC = 5'h0b,
		T_ST_ACCLO = 5'h0c, T_XC_YX = 5'h0d, T_XC_Y = 5'h0e, T_XC_YLO = 5'h0f,
		T_XC_ACC = 5'h10, T_XC_ACCLO = 5'h11
	} xfer_t;

	typedef enum logic [1:0] {PM_ZERO = 2'h0, PM_INC = 2'h1, PM_DEC = 2'h2, PM_INC2 = 2'h3} pmod_t;

	typedef struct packed {
		logic [11:0] spare_hi;
		logic [3:0]  rep;
		pmod_t       pmod;
		logic        moved_acc_select;
		xfer_t       xfer;
		logic [1:0]  spare_lo;
		logic        dest_acc;
		logic        source_accumulator;
		func_t       func;
	} instr_t;

	typedef enum logic [2:0] {ST_IDLE = 3'b001, ST_RUN = 3'b010, ST_HOLD = 3'b100} exec_state_t;
endpackage

// ---- tb/seq_master.sv ----
`timescale 1ns/1ps
module seq_master (
	// Clock
	input  wire logic        sys_clk,
	// Write channels
	output logic             awvalid,
	output logic [7:0]       awaddr,
	output logic             wvalid,
	output logic [31:0]      wdata,
	output logic [3:0]       wstrb,
	output logic             bready,
	input  wire logic        awready,
	input  wire logic        wready,
	input  wire logic        bvalid,
	input  wire logic [1:0]  bresp,
	// Read channels
	output logic             arvalid,
	output logic [7:0]       araddr,
	output logic             rready,
	input  wire logic        arready,
	input  wire logic        rvalid,
	input  wire logic [31:0] rdata,
	input  wire logic [1:0]  rresp
);
	initial begin
		{awvalid, wvalid, bready, arvalid, rready} = 5'h00;
		{awaddr, araddr} = 16'h0000;
		wdata = 32'h0000_0000;
		wstrb = 4'h0;
	end

	// Address and data offered together, each released when taken
	task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
		awvalid <= 1'b1;
		awaddr <= a;
		wvalid <= 1'b1;
		wdata <= d;
		wstrb <= 4'hf;
		bready <= 1'b1;
		do begin
			@(posedge sys_clk);
			if (awready) awvalid <= 1'b0;
			if (wready) wvalid <= 1'b0;
		end while (!bvalid);
		r = bresp;
		bready <= 1'b0;
		@(posedge sys_clk);
	endtask

	task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		arvalid <= 1'b1;
		araddr <= a;
		rready <= 1'b1;
		do begin
			@(posedge sys_clk);
			if (arready) arvalid <= 1'b0;
		end while (!rvalid);
		d = rdata;
		r = rresp;
		rready <= 1'b0;
		@(posedge sys_clk);
	endtask
endmodule

// ---- tb/multiply_alu_transfer_datapath_test.sv ----
`timescale 1ns/1ps
module multiply_alu_transfer_datapath_test;
	logic        sys_clk = 1'b0;
	logic        rst = 1'b1;
	logic        ce = 1'b1;
	logic        awvalid, wvalid, bready, arvalid, rready;
	logic        awready, wready, bvalid, arready, rvalid;
	logic [7:0]  awaddr, araddr;
	logic [31:0] wdata, rdata, rd;
	logic [3:0]  wstrb;
	logic [1:0]  bresp, rresp, resp;
	int          mismatches = 0;
	int          n_tests = 0;

	always #5 sys_clk = ~sys_clk;

	multiply_alu_transfer_datapath i_dut (.sys_clk, .rst, .ce, .awvalid, .awaddr, .awready,
		.wvalid, .wdata, .wstrb, .wready, .bvalid, .bresp, .bready, .arvalid, .araddr,
		.arready, .rvalid, .rdata, .rresp, .rready);

	seq_master i_seq (.sys_clk, .awvalid, .awaddr, .wvalid, .wdata, .wstrb, .bready,
		.awready, .wready, .bvalid, .bresp, .arvalid, .araddr, .rready, .arready,
		.rvalid, .rdata, .rresp);

	task automatic summarize;
		$display("comparisons %0d mismatches %0d", n_tests, mismatches);
		if (mismatches == 0 && n_tests > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask

	task automatic cmp(input logic [41:0] got, input logic [41:0] want);
		n_tests++;
		if (got !== want) begin
			mismatches++;
			$display("FAIL %0t got %h want %h", $time, got, want);
		end
	endtask

	task automatic chk(input logic [7:0] a, input logic [31:0] want);
		i_seq.rd(a, rd, resp);
		cmp({resp, a, rd}, {mac_alu_pkg::RESP_OKAY, a, want});
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		i_seq.wr(a, d, resp);
		cmp({40'h0, resp}, {40'h0, mac_alu_pkg::RESP_OKAY});
	endtask

	function automatic logic [31:0] mk(input mac_alu_pkg::func_t f, input logic d,
			input mac_alu_pkg::xfer_t t, input logic [3:0] n);
		mac_alu_pkg::instr_t i;
		i = '0;
		i.func = f;
		i.dest_acc = d;
		i.xfer = t;
		i.rep = n;
		return i;
	endfunction

	// Start an instruction, wait for idle, compare cycles taken
	task automatic run(input logic [31:0] ins, input logic [15:0] cyc);
		wr(mac_alu_pkg::OFS_INSTR, ins);
		do i_seq.rd(mac_alu_pkg::OFS_STATUS, rd, resp); while (rd[0] !== 1'b0);
		cmp({26'h0, rd[31:16]}, {26'h0, cyc});
	endtask

	initial begin
		repeat (20000) @(posedge sys_clk);
		mismatches++;
		summarize();
	end

	initial begin
		repeat (16) @(posedge sys_clk);
		rst <= 1'b0;
		@(posedge sys_clk);
		chk(mac_alu_pkg::OFS_CTRL, 32'h0000_0000);
		i_seq.rd(8'h3c, rd, resp);
		cmp({8'h00, resp, rd}, {8'h00, mac_alu_pkg::RESP_SLVERR, 32'h0000_0000});
		wr(mac_alu_pkg::OFS_X, 32'h0000_fffd);
		wr(mac_alu_pkg::OFS_Y, 32'h0005_abcd);
		run(mk(mac_alu_pkg::F_MUL, 1'b0, mac_alu_pkg::T_NONE, 4'h0), 16'h0001);
		chk(mac_alu_pkg::OFS_P, 32'hffff_fff1);
		run(mk(mac_alu_pkg::F_P, 1'b0, mac_alu_pkg::T_NONE, 4'h0), 16'h0001);
		chk(mac_alu_pkg::OFS_A0_LO, 32'hffff_fff1);
		chk(mac_alu_pkg::OFS_A0_HI, 32'h0000_000f);
		wr(mac_alu_pkg::OFS_CTRL, 32'h0000_0001);
		wr(mac_alu_pkg::OFS_X, 32'h0000_0002);
		run(mk(mac_alu_pkg::F_P_MUL, 1'b1, mac_alu_pkg::T_NONE, 4'h0), 16'h0001);
		chk(mac_alu_pkg::OFS_A1_LO, 32'hffff_fffc);
		chk(mac_alu_pkg::OFS_P, 32'h0000_000a);
		wr(mac_alu_pkg::OFS_CTRL, 32'h0000_0000);
		run(mk(mac_alu_pkg::F_SUBP, 1'b0, mac_alu_pkg::T_NONE, 4'h0), 16'h0001);
		chk(mac_alu_pkg::OFS_A0_LO, 32'hffff_ffe7);
		run(mk(mac_alu_pkg::F_XOR, 1'b1, mac_alu_pkg::T_NONE, 4'h0), 16'h0001);
		chk(mac_alu_pkg::OFS_A1_LO, 32'hfffa_542a);
		run(mk(mac_alu_pkg::F_CMPSUB, 1'b1, mac_alu_pkg::T_NONE, 4'h0), 16'h0001);
		chk(mac_alu_pkg::OFS_A1_LO, 32'hfffa_542a);
		chk(mac_alu_pkg::OFS_STATUS, 32'h0001_0002);
		run(mk(mac_alu_pkg::F_ADDY, 1'b1, mac_alu_pkg::T_NONE, 4'h0), 16'h0001);
		chk(mac_alu_pkg::OFS_A1_LO, 32'h0005_abb4);
		chk(mac_alu_pkg::OFS_A1_HI, 32'h0000_0000);
		wr(8'h40, 32'h0000_1234);
		wr(mac_alu_pkg::OFS_PTR, 32'h0000_0000);
		run(mk(mac_alu_pkg::F_Y, 1'b0, mac_alu_pkg::T_LD_Y, 4'h0), 16'h0001);
		chk(mac_alu_pkg::OFS_Y, 32'h1234_0000);
		chk(mac_alu_pkg::OFS_A0_LO, 32'h0005_abcd);
		wr(mac_alu_pkg::OFS_PTR, 32'h0000_0001);
		run(mk(mac_alu_pkg::F_NONE, 1'b0, mac_alu_pkg::T_ST_Y, 4'h0), 16'h0002);
		chk(8'h44, 32'h0000_1234);
		run(mk(mac_alu_pkg::F_NONE, 1'b0, mac_alu_pkg::T_NONE, 4'h4), 16'h0004);
		wr(8'h44, 32'h0000_8001);
		run(mk(mac_alu_pkg::F_NONE, 1'b0, mac_alu_pkg::T_LD_ACC, 4'h0), 16'h0001);
		chk(mac_alu_pkg::OFS_A0_LO, 32'h8001_0000);
		chk(mac_alu_pkg::OFS_A0_HI, 32'h0000_000f);
		run(mk(mac_alu_pkg::F_NONE, 1'b0, mac_alu_pkg::T_LD_YLO, 4'h0), 16'h0001);
		chk(mac_alu_pkg::OFS_Y, 32'h1234_8001);
		run(mk(mac_alu_pkg::F_NONE, 1'b0, mac_alu_pkg::T_ADDR, 4'h0) | 32'h0000_4000, 16'h0001);
		chk(mac_alu_pkg::OFS_PTR, 32'h0000_0002);
		chk(mac_alu_pkg::OFS_Y, 32'h1234_8001);
		wr(8'h48, 32'h0000_0003);
		wr(8'h80, 32'h0000_0007);
		run(mk(mac_alu_pkg::F_NONE, 1'b0, mac_alu_pkg::T_LD_YX, 4'h0), 16'h0001);
		chk(mac_alu_pkg::OFS_Y, 32'h0003_0000);
		chk(mac_alu_pkg::OFS_X, 32'h0000_0007);
		chk(mac_alu_pkg::OFS_PTR, 32'h0000_0102);
		run(mk(mac_alu_pkg::F_SUBY, 1'b0, mac_alu_pkg::T_NONE, 4'h0), 16'h0001);
		chk(mac_alu_pkg::OFS_A0_LO, 32'h7ffe_0000);
		chk(mac_alu_pkg::OFS_A0_HI, 32'h0000_000f);
		wr(mac_alu_pkg::OFS_CTRL, 32'h0000_0010);
		run(mk(mac_alu_pkg::F_NONE, 1'b0, mac_alu_pkg::T_ST_ACC, 4'h0), 16'h0002);
		chk(8'h48, 32'h0000_8000);
		summarize();
	end
endmodule
